/* rtl/bsc_tx_pkg.sv */
package bsc_tx_pkg;

   // =====================================================
   // Register map
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] TXDATA_OFF = 8'h08;
   localparam logic [7:0] BCC_OFF    = 8'h0c;

   // =====================================================
   // Control field positions
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_CODE_LSB   = 1;
   localparam int CTRL_CHECK_LSB  = 3;
   localparam int CTRL_STXINC_BIT = 5;
   localparam int CTRL_ITBOPT_LSB = 6;
   localparam int CTRL_FILL_BIT   = 8;
   localparam int CTRL_LOCK_BIT   = 9;

   // Status field positions
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_LOCK_BIT  = 2;
   localparam int ST_FULL_BIT  = 3;
   localparam int ST_URUN_BIT  = 4;
   localparam int ST_TOUT_BIT  = 5;
   localparam int ST_URST_BIT  = 6;
   localparam int ST_CFGE_BIT  = 7;

   localparam logic [9:0] CTRL_RESET = 10'h000;

   // =====================================================
   // Codings, check types and intermediate-block options
   typedef enum logic [1:0] {CODE_EBCDIC, CODE_ASCII7, CODE_ASCII8,
                             CODE_RSVD} code_t;
   typedef enum logic [1:0] {CHK_CRC_B, CHK_CRC_S, CHK_LRC,
                             CHK_RSVD} check_t;
   typedef enum logic [1:0] {ITB_DATA, ITB_MODE, ITB_EIB,
                             ITB_RSVD} itb_opt_t;
   typedef enum logic [1:0] {MODE_CONTROL, MODE_NORMAL,
                             MODE_TRANSP} tx_mode_t;

   typedef struct packed {
      logic     fill_opt;
      itb_opt_t itb_opt;
      logic     stx_incl;
      check_t   check;
      code_t    code;
   } cfg_t;

   // =====================================================
   // Control characters, EBCDIC and ASCII
   localparam logic [7:0] E_SOH = 8'h01, A_SOH = 8'h01;
   localparam logic [7:0] E_STX = 8'h02, A_STX = 8'h02;
   localparam logic [7:0] E_ETX = 8'h03, A_ETX = 8'h03;
   localparam logic [7:0] E_DLE = 8'h10, A_DLE = 8'h10;
   localparam logic [7:0] E_ITB = 8'h1f, A_ITB = 8'h1f;
   localparam logic [7:0] E_ETB = 8'h26, A_ETB = 8'h17;
   localparam logic [7:0] E_ENQ = 8'h2d, A_ENQ = 8'h05;
   localparam logic [7:0] E_SYN = 8'h32, A_SYN = 8'h16;

   // Reflected polynomials, bit 0 sent first
   localparam logic [15:0] CRC_B_POLY = 16'ha001;
   localparam logic [15:0] CRC_S_POLY = 16'h8408;
   localparam logic [15:0] BCC_INIT   = 16'h0000;

   // =====================================================
   // Timing
   localparam int unsigned CLK_KHZ      = 200000;
   localparam int unsigned FILL_TIME_MS = 1000;
   localparam int unsigned FILL_CYCLES  = FILL_TIME_MS * CLK_KHZ;
   localparam int unsigned BIT_DIV      = 16;

endpackage

/* rtl/bsc_transmit_framer.sv */
`timescale 1ns/100ps
module bsc_transmit_framer
   import bsc_tx_pkg::*;
#(
   parameter int unsigned FILL_CYC = FILL_CYCLES,
   parameter int unsigned DIV      = BIT_DIV
)(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             line_txd,
   output logic             l2_irq
);

   // =====================================================
   // State
   cfg_t        cfg_reg;
   tx_mode_t    mode_reg, mode_next;
   logic        lock_reg, lock_next;
   logic        dle_reg, dle_next;
   logic        del_reg, del_next;
   logic [7:0]  pend_reg [2];
   logic [7:0]  pend_next [2];
   logic [1:0]  pcnt_reg, pcnt_next;
   logic [15:0] bcc_reg, bcc_next;
   logic        fill_req_reg;
   logic        urun_reg, urun_next;
   logic        tout_st_reg, urun_st_reg;
   logic [7:0]  hold_reg;
   logic        full_reg;
   logic [7:0]  shift_reg;
   logic [3:0]  left_reg;
   logic [15:0] div_reg;
   logic [31:0] tmr_reg;
   logic        go, take;
   logic [7:0]  ch;
   logic        bit_tick, slot, tmr_hit, start_wr, lock_wr;
   logic        acc_w, ctl_w, cfg_err;
   check_t      eff_chk;

   // =====================================================
   // Helpers
   function automatic logic [15:0] acc(input logic [15:0] b,
                                        input logic [7:0] c,
                                        input check_t t);
      logic [15:0] r;
      r = b;
      if (t == CHK_LRC)
         r = {8'h00, b[7:0] ^ c};
      else
         for (int i = 0; i < 8; i++)
         begin
            if (r[0] ^ c[i])
               r = (r >> 1) ^ ((t == CHK_CRC_B) ? CRC_B_POLY
                                                : CRC_S_POLY);
            else
               r = r >> 1;
         end
      return r;
   endfunction

   function automatic logic [7:0] sym(input logic asc,
                                      input logic [7:0] e,
                                      input logic [7:0] a);
      return asc ? a : e;
   endfunction

   // =====================================================
   // Bit-rate divider and timer
   assign bit_tick = (div_reg == 16'(DIV - 1));
   assign slot     = bit_tick && (left_reg == 4'h0);
   assign tmr_hit  = (tmr_reg == FILL_CYC - 1);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         div_reg <= 16'h0000;
      else if (bit_tick)
         div_reg <= 16'h0000;
      else
         div_reg <= div_reg + 16'h0001;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         tmr_reg <= 32'h0000_0000;
      else if (mode_reg == MODE_CONTROL || tmr_hit)
         tmr_reg <= 32'h0000_0000;
      else
         tmr_reg <= tmr_reg + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         fill_req_reg <= 1'b0;
      else if (tmr_hit && cfg_reg.fill_opt)
         fill_req_reg <= 1'b1;
      else if (slot && pcnt_reg == 2'd0 && !lock_reg)
         fill_req_reg <= 1'b0;
   end

   // =====================================================
   // Character engine
   assign cfg_err = (mode_reg == MODE_TRANSP) && (cfg_reg.check == CHK_LRC);
   assign eff_chk = cfg_err ? CHK_CRC_S : cfg_reg.check;

   always_comb
   begin
      logic       asc;
      logic [7:0] c;
      logic [15:0] nb;
      asc       = (cfg_reg.code != CODE_EBCDIC);
      c         = (cfg_reg.code == CODE_ASCII7) ? {1'b0, hold_reg[6:0]}
                                                : hold_reg;
      nb        = acc(bcc_reg, c, eff_chk);
      mode_next = mode_reg;
      lock_next = lock_reg;
      dle_next  = dle_reg;
      del_next  = del_reg;
      pend_next = pend_reg;
      pcnt_next = pcnt_reg;
      bcc_next  = bcc_reg;
      urun_next = urun_reg;
      acc_w     = 1'b0;
      ctl_w     = 1'b0;
      go        = 1'b0;
      take      = 1'b0;
      ch        = 8'h00;
      // Drop the char after an EIB-mode ITB while check bytes go out
      if (del_reg && full_reg && !(slot && pcnt_reg == 2'd0))
      begin
         take     = 1'b1;
         del_next = 1'b0;
      end
      if (slot)
      begin
         if (pcnt_reg != 2'd0)
         begin
            go           = 1'b1;
            ch           = pend_reg[0];
            pend_next[0] = pend_reg[1];
            pcnt_next    = pcnt_reg - 2'd1;
         end
         else if (mode_reg != MODE_CONTROL && fill_req_reg && !lock_reg)
         begin
            // Fill pair, never accumulated
            go           = 1'b1;
            ch           = (mode_reg == MODE_NORMAL)
                           ? sym(asc, E_SYN, A_SYN)
                           : sym(asc, E_DLE, A_DLE);
            pend_next[0] = sym(asc, E_SYN, A_SYN);
            pcnt_next    = 2'd1;
         end
         else if (full_reg)
         begin
            take      = 1'b1;
            urun_next = 1'b0;
            if (del_reg)
               del_next = 1'b0;
            else
            begin
               go = 1'b1;
               ch = c;
               unique case (mode_reg)
                  MODE_CONTROL:
                  begin
                     dle_next = (c == sym(asc, E_DLE, A_DLE));
                     if (c == sym(asc, E_STX, A_STX))
                     begin
                        mode_next = dle_reg ? MODE_TRANSP
                                            : MODE_NORMAL;
                        if (cfg_reg.stx_incl)
                           bcc_next = nb;
                     end
                     else if (c == sym(asc, E_SOH, A_SOH))
                        mode_next = MODE_NORMAL;
                  end
                  MODE_NORMAL:
                  begin
                     dle_next  = 1'b0;
                     lock_next = 1'b0;
                     if (dle_reg && c == sym(asc, E_STX, A_STX))
                        mode_next = MODE_TRANSP;
                     else if (c == sym(asc, E_DLE, A_DLE))
                     begin
                        lock_next = 1'b1;
                        dle_next  = 1'b1;
                     end
                     else if (c == sym(asc, E_ENQ, A_ENQ))
                        ctl_w = 1'b1;
                     else if (c == sym(asc, E_ETB, A_ETB) ||
                              c == sym(asc, E_ETX, A_ETX))
                     begin
                        acc_w = 1'b1;
                        ctl_w = 1'b1;
                     end
                     else if (c == sym(asc, E_ITB, A_ITB))
                     begin
                        lock_next = 1'b1;
                        if (cfg_reg.itb_opt == ITB_DATA)
                           bcc_next = nb;
                        else
                        begin
                           acc_w    = 1'b1;
                           del_next = (cfg_reg.itb_opt == ITB_EIB);
                        end
                     end
                     else if (c != sym(asc, E_SYN, A_SYN))
                        bcc_next = nb;
                  end
                  default:
                  begin
                     dle_next = 1'b0;
                     if (dle_reg)
                     begin
                        lock_next = 1'b0;
                        if (c == sym(asc, E_ENQ, A_ENQ))
                           ctl_w = 1'b1;
                        else if (c == sym(asc, E_ETB, A_ETB) ||
                                 c == sym(asc, E_ETX, A_ETX))
                        begin
                           acc_w = 1'b1;
                           ctl_w = 1'b1;
                        end
                        else if (c == sym(asc, E_ITB, A_ITB) &&
                                 cfg_reg.itb_opt != ITB_DATA)
                        begin
                           acc_w     = 1'b1;
                           mode_next = MODE_NORMAL;
                           del_next  = (cfg_reg.itb_opt == ITB_EIB);
                        end
                        else
                           bcc_next = nb;
                     end
                     else if (c == sym(asc, E_DLE, A_DLE))
                     begin
                        if (lock_reg)
                           dle_next = 1'b1;
                        else
                        begin
                           pend_next[0] = c;
                           pcnt_next    = 2'd1;
                           bcc_next     = nb;
                        end
                     end
                     else
                        bcc_next = nb;
                  end
               endcase
               if (acc_w)
               begin
                  // Check bytes follow the ending character
                  pend_next[0] = nb[7:0];
                  pend_next[1] = nb[15:8];
                  pcnt_next    = (eff_chk == CHK_LRC) ? 2'd1 : 2'd2;
                  bcc_next     = BCC_INIT;
               end
               if (ctl_w)
               begin
                  mode_next = MODE_CONTROL;
                  bcc_next  = BCC_INIT;
                  lock_next = 1'b0;
               end
            end
         end
         else if (mode_reg != MODE_CONTROL)
         begin
            // Underrun fill, never accumulated
            go           = 1'b1;
            urun_next    = 1'b1;
            ch           = (mode_reg == MODE_NORMAL)
                           ? sym(asc, E_SYN, A_SYN)
                           : sym(asc, E_DLE, A_DLE);
            pend_next[0] = sym(asc, E_SYN, A_SYN);
            pcnt_next    = 2'd1;
         end
         if (go && cfg_reg.code == CODE_ASCII7 && mode_reg != MODE_TRANSP)
            ch = {~^ch[6:0], ch[6:0]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_reg    <= MODE_CONTROL;
         lock_reg    <= 1'b0;
         dle_reg     <= 1'b0;
         del_reg     <= 1'b0;
         pend_reg[0] <= 8'h00;
         pend_reg[1] <= 8'h00;
         pcnt_reg    <= 2'd0;
         bcc_reg     <= BCC_INIT;
         urun_reg    <= 1'b0;
      end
      else if (start_wr)
      begin
         mode_reg <= MODE_CONTROL;
         lock_reg <= 1'b0;
         dle_reg  <= 1'b0;
         del_reg  <= 1'b0;
         pcnt_reg <= 2'd0;
         bcc_reg  <= BCC_INIT;
         urun_reg <= 1'b0;
      end
      else
      begin
         mode_reg  <= mode_next;
         lock_reg  <= lock_next || lock_wr;
         dle_reg   <= dle_next;
         del_reg   <= del_next;
         pend_reg  <= pend_next;
         pcnt_reg  <= pcnt_next;
         bcc_reg   <= bcc_next;
         urun_reg  <= urun_next;
      end
   end

   // =====================================================
   // Serializer, low bit first, mark when idle
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_reg <= 8'h00;
         left_reg  <= 4'h0;
         line_txd  <= 1'b1;
      end
      else if (slot && go)
      begin
         line_txd  <= ch[0];
         shift_reg <= {1'b0, ch[7:1]};
         left_reg  <= 4'h7;
      end
      else if (bit_tick && left_reg != 4'h0)
      begin
         line_txd  <= shift_reg[0];
         shift_reg <= {1'b0, shift_reg[7:1]};
         left_reg  <= left_reg - 4'h1;
      end
      else if (slot)
         line_txd <= 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         l2_irq <= 1'b0;
      else
         l2_irq <= urun_next || (tmr_hit && !cfg_reg.fill_opt);
   end

   // =====================================================
   // APB slave, one wait state
   logic acc_ph, wr_ok, sel_ok;
   assign acc_ph   = psel && penable && !pready;
   assign sel_ok   = (paddr == CTRL_OFF) || (paddr == STATUS_OFF) ||
                     (paddr == TXDATA_OFF) || (paddr == BCC_OFF);
   assign wr_ok    = acc_ph && pwrite;
   assign start_wr = wr_ok && paddr == CTRL_OFF && pwdata[CTRL_START_BIT];
   assign lock_wr  = wr_ok && paddr == CTRL_OFF && pwdata[CTRL_LOCK_BIT];

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         cfg_reg <= cfg_t'(CTRL_RESET[8:1]);
      else if (wr_ok && paddr == CTRL_OFF)
         cfg_reg <= cfg_t'(pwdata[CTRL_FILL_BIT:CTRL_CODE_LSB]);
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_reg <= 8'h00;
         full_reg <= 1'b0;
      end
      else if (wr_ok && paddr == TXDATA_OFF && (!full_reg || take))
      begin
         hold_reg <= pwdata[7:0];
         full_reg <= 1'b1;
      end
      else if (take || start_wr)
         full_reg <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tout_st_reg <= 1'b0;
         urun_st_reg <= 1'b0;
      end
      else
      begin
         if (tmr_hit && !cfg_reg.fill_opt)
            tout_st_reg <= 1'b1;
         else if (wr_ok && paddr == STATUS_OFF && pwdata[ST_TOUT_BIT])
            tout_st_reg <= 1'b0;
         if (urun_next && !urun_reg)
            urun_st_reg <= 1'b1;
         else if (wr_ok && paddr == STATUS_OFF && pwdata[ST_URST_BIT])
            urun_st_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= acc_ph;
         pslverr <= acc_ph && (!sel_ok || (pwrite &&
                    paddr == TXDATA_OFF && full_reg && !take));
         prdata  <= 32'h0000_0000;
         if (acc_ph && !pwrite)
            unique case (paddr)
               CTRL_OFF:
                  prdata <= {22'h0, lock_reg, cfg_reg, 1'b0};
               STATUS_OFF:
                  prdata <= {24'h000000, cfg_err, urun_st_reg,
                             tout_st_reg, urun_reg, full_reg,
                             lock_reg, mode_reg};
               BCC_OFF:
                  prdata <= {16'h0000, bcc_reg};
               default:
                  prdata <= 32'h0000_0000;
            endcase
      end
   end

endmodule

/* testbench/bsc_framer_properties.sv */
`timescale 1ns/100ps
module bsc_framer_checker
   import bsc_tx_pkg::*;
#(parameter int unsigned DIV = BIT_DIV)(
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        line_txd,
   input wire logic        l2_irq
);
   // ====
   // Line change tracking
   int unsigned run;
   logic        prev;
   logic        seen;
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         run  <= 0;
         prev <= 1'b1;
         seen <= 1'b0;
      end
      else
      begin
         prev <= line_txd;
         run  <= (line_txd != prev) ? 0 : run + 1;
         seen <= seen | (line_txd != prev);
      end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // ====
   // Properties
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   AST_ONE_WAIT: assert property (s_taken |=> s_answer)
      else $error("answer not one cycle after take");
   AST_NO_STRAY: assert property (pready |-> $past(psel && penable))
      else $error("pready without request");
   AST_RDATA_ZERO: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without pready");
   AST_UNMAPPED: assert property (psel && penable && !pready &&
      !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=> pslverr)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (psel && penable && !pready &&
      (paddr inside {8'h00, 8'h04, 8'h0c}) |=> !pslverr)
      else $error("mapped access refused");
   AST_BIT_SPACING: assert property (
      seen && line_txd != prev |-> (run + 1) % DIV == 0)
      else $error("line bit not a whole bit time");
   AST_IDLE_AFTER_RESET: assert property (
      $rose(rst_b) |-> (line_txd && !l2_irq) [*4])
      else $error("line not idle after reset");
endmodule

bind bsc_transmit_framer bsc_framer_checker #(.DIV(DIV)) checker_i (
   .ref_clk, .rst_b, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .line_txd, .l2_irq);

/* testbench/bsc_remote_station.sv */
`timescale 1ns/100ps
module bsc_remote_station #(
   parameter int DIV = 4
)(
   input wire logic ref_clk,
   input wire logic line_txd,
   input wire logic clear
);
   // ====
   // Character capture, LSB first
   logic [7:0] got[$];
   logic [7:0] sh;
   int         ph;
   int         nb;
   logic       hunt = 1'b1;

   always @(posedge ref_clk)
   begin
      if (clear)
      begin
         hunt = 1'b1;
         got.delete();
      end
      else if (hunt)
      begin
         hunt = line_txd;
         ph = 0;
         nb = 0;
      end
      else if (ph != 0)
         ph = ph - 1;
      else
      begin
         sh = {line_txd, sh[7:1]};
         nb = nb + 1;
         ph = DIV - 1;
         if (nb == 8)
         begin
            got.push_back(sh);
            nb = 0;
         end
      end
   end
endmodule

/* testbench/tb_bsc_transmit_framer.sv */
`timescale 1ns/100ps
module tb_bsc_transmit_framer;
   import bsc_tx_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        line_txd;
   logic        l2_irq;
   logic        clear = 1'b0;
   logic [31:0] rd;
   logic        er;
   int          n_errors = 0;
   int          n_tests = 0;

   bsc_transmit_framer #(.FILL_CYC(1000), .DIV(4)) bsc_transmit_framer_i (
      .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .line_txd, .l2_irq);
   bsc_remote_station #(.DIV(4)) bsc_remote_station_i (
      .ref_clk, .line_txd, .clear);

   initial forever #2.5 ref_clk = ~ref_clk;

   // ====
   // Shared tasks
   task automatic wrap_up;
      $display("Tests %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic stall(input string w);
      n_errors++;
      $display("FAIL %s expected done seen timeout", w);
      wrap_up();
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         stall("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_st(input logic [31:0] m, input logic [31:0] v,
                          input int l);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, STATUS_OFF, 32'h0);
         n++;
      end
      while ((rd & m) !== v && n < l);
      if ((rd & m) !== v)
         stall("status");
   endtask

   task automatic put(input logic [7:0] c);
      wait_st(32'h8, 32'h0, 40);
      apb(1'b1, TXDATA_OFF, {24'h0, c});
   endtask

   task automatic restart(input logic [31:0] cfg);
      apb(1'b1, CTRL_OFF, cfg);
      clear <= 1'b1;
      @(posedge ref_clk);
      clear <= 1'b0;
   endtask

   task automatic see(input logic [7:0] e[$]);
      int n;
      n = 0;
      while (bsc_remote_station_i.got.size() < e.size() && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000)
         stall("line");
      for (int i = 0; i < e.size(); i++)
         chk("line char", 32'(e[i]), 32'(bsc_remote_station_i.got[i]));
   endtask

   function automatic logic [15:0] crc(input logic [15:0] c,
                                       input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? (r >> 1) ^ CRC_S_POLY : r >> 1;
      return r;
   endfunction

   // ====
   // Scenarios
   task automatic t_reset;
      chk("line idle", 32'h1, {31'h0, line_txd});
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("status", 32'h0, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      $display("Test reset done");
   endtask

   task automatic t_lrc;
      restart(32'h11);
      put(E_STX);
      put(8'h41);
      put(E_SYN);
      put(E_ETX);
      see({E_STX, 8'h41, E_SYN, E_ETX, 8'h41 ^ E_ETX});
      wait_st(32'h3, 32'h0, 40);
      $display("Test lrc done");
   endtask

   task automatic t_enq;
      restart(32'h3);
      put(A_STX);
      put(8'h41);
      put(A_ENQ);
      see({A_STX, 8'hc1, 8'h85, 8'hff});
      wait_st(32'h3, 32'h0, 40);
      $display("Test enq done");
   endtask

   task automatic t_transp;
      logic [15:0] c;
      c = crc(crc(16'h0, E_DLE), E_ETX);
      restart(32'h9);
      put(E_DLE);
      put(E_STX);
      wait_st(32'h3, 32'h2, 40);
      put(E_DLE);
      wait_st(32'h8, 32'h0, 40);
      apb(1'b1, CTRL_OFF, 32'h208);
      put(E_DLE);
      put(E_ETX);
      see({E_DLE, E_STX, E_DLE, E_DLE, E_DLE, E_ETX, c[7:0], c[15:8]});
      wait_st(32'h3, 32'h0, 40);
      $display("Test transparent done");
   endtask

   task automatic t_urun;
      int n;
      restart(32'h1);
      put(E_STX);
      n = 0;
      while (l2_irq !== 1'b1 && n < 200)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk("underrun irq", 32'h1, {31'h0, l2_irq});
      see({E_STX, E_SYN, E_SYN});
      wait_st(32'h30, 32'h30, 400);
      put(E_ETX);
      wait_st(32'h3, 32'h0, 100);
      apb(1'b1, STATUS_OFF, 32'h60);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("status idle", 32'h0, rd);
      $display("Test underrun done");
   endtask

   task automatic t_eib;
      logic [15:0] c1;
      logic [15:0] c2;
      logic [7:0]  q[$];
      c1 = crc(crc(16'h0, 8'h41), E_ITB);
      c2 = crc(16'h0, E_ETX);
      q = {E_STX, 8'h41, E_ITB, c1[7:0], c1[15:8], E_ETX,
           c2[7:0], c2[15:8]};
      restart(32'h189);
      apb(1'b0, CTRL_OFF, 32'h0);
      chk("ctrl", 32'h188, rd);
      put(E_STX);
      put(8'h41);
      put(E_ITB);
      put(8'h55);
      put(E_ETX);
      see(q);
      wait_st(32'h3, 32'h0, 40);
      $display("Test eib done");
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_lrc();
      t_enq();
      t_transp();
      t_eib();
      t_urun();
      wrap_up();
   end
endmodule
